// [rtl/wdg_defines.vh]
// constants for the watchdog reset timer: register layout, reset value, timing
// assumes a 20 MHz core clock; included by the design files by bare name
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

`define WDG_REG_RESET      8'hFE
`define WDG_ACT_BIT        0
`define WDG_SENSE_BIT      1
`define WDG_CLK_PERIOD_NS  50
`define WDG_TICK_CYCLES    3072
`define WDG_TICK_W         12
`define WDG_PULSE_NS       500
`define WDG_PULSE_CYCLES   ((`WDG_PULSE_NS) / (`WDG_CLK_PERIOD_NS))
`define WDG_PULSE_W        4

`endif

// [rtl/wdg_prescaler.v]
// tick generator: one pulse every 3072 core clocks while enabled
// assumes enable is a level gated from registers in the watchdog core
`timescale 1ns/100ps
`include "wdg_defines.vh"
`default_nettype none

module wdg_prescaler (
    input  wire        core_clk,   // core clock
    input  wire        reset_n,    // async reset, active low
    input  wire        run,        // count while high, hold while low
    input  wire        restart,    // restart the interval (on reload)
    output reg         tick        // one-cycle pulse at interval end
);

    reg [`WDG_TICK_W-1:0] count;          // cycles into the current interval
    wire [31:0]           interval_last;  // interval length less one, full width

    // only the counter's width of the last index is compared
    assign interval_last = `WDG_TICK_CYCLES - 1;

    // interval counter; holding (not clearing) on run low keeps a frozen
    // watchdog resuming where it stopped
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 12'h000;
            tick  <= 1'b0;
        end else if (restart) begin
            count <= 12'h000;
            tick  <= 1'b0;
        end else if (run) begin
            if (count == interval_last[`WDG_TICK_W-1:0]) begin
                count <= 12'h000;
                tick  <= 1'b1;
            end else begin
                count <= count + 12'h001;
                tick  <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule // wdg_prescaler

`default_nettype wire

// [rtl/watchdog_reset_timer.v]
// watchdog reset timer: count register, activation, reset pulse, stop control
// assumes software access as a write strobe with data and a read-back port
//
// How it works
// - hardware option: always active, activate bit forced
// - hardware option: activate bit read carries no meaning
// - software option: set bit activates until reset
// - active counter decrements every 3072 clocks
// - timeout programmable in 64 interval steps
// - sense bit cleared while active: 500ns reset
// - clearing sense while active resets immediately
// - register resets FEh, reversed count, sense, activate
// - stop with pin high freezes counter
`timescale 1ns/100ps
`include "wdg_defines.vh"
`default_nettype none

module watchdog_reset_timer (
    input  wire        core_clk,                      // core clock, 20 MHz
    input  wire        reset_n,                       // async reset, active low
    input  wire        activation_select_option,      // 1 = hardware activation
    input  wire        external_stop_control_option,  // 1 = stop control enabled
    input  wire        nonmaskable_interrupt_pin,     // interrupt pin level
    input  wire        reg_write,                     // count register write strobe
    input  wire [7:0]  reg_wdata,                     // count register write data
    input  wire        stop_request,                  // cpu executes stop (pulse)
    input  wire        stop_exit,                     // wakeup ends stop (pulse)
    output reg  [7:0]  watchdog_count_register,       // register read-back
    output reg         watchdog_active,               // watchdog running
    output reg         stop_granted,                  // cpu may enter stop
    output reg         wait_instead,                  // stop taken as wait (pulse)
    output reg         reset_pin_n,                   // reset pin level, low = reset
    output reg         reset_pin_oe                   // reset pin driven low
);

    // register image, msb to lsb: count field bit 0 at bit 7 up to count
    // field bit 5 at bit 2, then the sense bit, then the activate bit; the
    // count field is stored reversed, so a plain decrement of the byte would
    // be wrong and every tick goes through count_of and back through rev6
    //
    // the sense bit doubles as bit 6 of a seven-bit down-counter: when it
    // drops to zero the watchdog has run out, with no extra compare needed
    reg                    hw_option;      // option caught after reset release
    reg                    option_valid;   // option has been caught
    reg                    soft_active;    // software activation latched
    reg                    frozen;         // counter held in stop
    reg [`WDG_PULSE_W-1:0] pulse_count;    // reset pulse cycles left
    reg                    fire;           // start reset pulse next cycle
    wire                   tick;           // interval end from prescaler
    wire                   active_now;     // effective activation
    wire                   hw_forced;      // hardware option in force
    wire [31:0]            pulse_last;     // pulse length less one, full width

    // bit-reverse the six count bits: field bit 0 sits at register bit 7
    function [5:0] rev6;
        input [5:0] v;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                rev6[i] = v[5-i];
        end
    endfunction

    // seven-bit count value (sense bit is its msb) from a register image
    function [6:0] count_of;
        input [7:0] r;
        begin
            count_of = {r[`WDG_SENSE_BIT], rev6(r[7:2])};
        end
    endfunction

    // effective activation from the latched option or software bit
    // hardware option counts only once the strap has been caught, so the
    // first cycle after reset release is always inactive
    assign hw_forced  = option_valid & hw_option;
    assign active_now = hw_forced | soft_active;

    // the pulse counter is four bits wide; keep only what fits
    assign pulse_last = `WDG_PULSE_CYCLES - 1;

    // interval generator runs only while active and not frozen in stop
    wdg_prescaler u_prescaler (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .run      (active_now & ~frozen),
        .restart  (reg_write),
        .tick     (tick)
    );

    // option strap caught by a clocked process once reset is released
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hw_option    <= 1'b0;
            option_valid <= 1'b0;
        end else if (!option_valid) begin
            hw_option    <= activation_select_option;
            option_valid <= 1'b1;
        end
    end

    // count register: a write loads all bits at once, else ticks count down;
    // the sense bit is the counter msb so 64 steps from 7Fh reach it clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_count_register <= `WDG_REG_RESET;
            soft_active             <= 1'b0;
        end else begin
            if (reg_write) begin
                // activate bit is forced high under hardware option; software
                // may only set it under software option, never clear it
                watchdog_count_register <= {reg_wdata[7:1],
                    reg_wdata[`WDG_ACT_BIT] | hw_forced
                    | soft_active};
                if (reg_wdata[`WDG_ACT_BIT])
                    soft_active <= 1'b1;
            end else if (tick) begin
                // decrement the reversed field plus sense bit as one value
                watchdog_count_register <=
                    {rev6(dec_lo(watchdog_count_register)),
                     dec_hi(watchdog_count_register),
                     watchdog_count_register[`WDG_ACT_BIT] | hw_forced};
            end else if (hw_forced) begin
                // reset value reads the activate bit as zero; under the hardware
                // option it is raised as soon as the strap is known, so reads
                // agree with the always-active state from then on
                watchdog_count_register[`WDG_ACT_BIT] <= 1'b1;
            end
        end
    end

    // low six bits of the decremented count
    function [5:0] dec_lo;
        input [7:0] r;
        reg   [6:0] d;
        begin
            d      = count_of(r) - 7'h01;
            dec_lo = d[5:0];
        end
    endfunction

    // sense bit of the decremented count
    function dec_hi;
        input [7:0] r;
        reg   [6:0] d;
        begin
            d      = count_of(r) - 7'h01;
            dec_hi = d[6];
        end
    endfunction

    // reset trigger: sense bit clear while active, by timeout or by a
    // software write clearing it (the latter is the software reset)
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fire            <= 1'b0;
            watchdog_active <= 1'b0;
        end else begin
            watchdog_active <= active_now;
            fire <= active_now & ~watchdog_count_register[`WDG_SENSE_BIT]
                    & (pulse_count == 4'h0);
        end
    end

    // reset pulse of nominal length on the reset pin; this block's own
    // reset then comes back through reset_n from the system; the pin is
    // released for one cycle between pulses, so a board that never routes
    // it back into reset_n sees a train of pulses rather than a stuck low
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_count  <= 4'h0;
            reset_pin_n  <= 1'b1;
            reset_pin_oe <= 1'b0;
        end else if (fire && pulse_count == 4'h0) begin
            pulse_count  <= pulse_last[`WDG_PULSE_W-1:0];
            reset_pin_n  <= 1'b0;
            reset_pin_oe <= 1'b1;
        end else if (pulse_count != 4'h0) begin
            pulse_count  <= pulse_count - 4'h1;
        end else begin
            reset_pin_n  <= 1'b1;
            reset_pin_oe <= 1'b0;
        end
    end

    // stop handling: inactive watchdog lets stop through; active watchdog
    // freezes only with stop control enabled and the interrupt pin high,
    // otherwise stop degrades to wait and the counter keeps running;
    // a request that meets stop_exit in one cycle is dropped, so the cpu
    // never stays stopped with no wakeup left pending
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            frozen       <= 1'b0;
            stop_granted <= 1'b0;
            wait_instead <= 1'b0;
        end else begin
            wait_instead <= 1'b0;
            if (stop_exit) begin
                frozen       <= 1'b0;
                stop_granted <= 1'b0;
            end else if (stop_request && !stop_granted) begin
                if (!active_now) begin
                    stop_granted <= 1'b1;
                end else if (external_stop_control_option
                             && nonmaskable_interrupt_pin) begin
                    frozen       <= 1'b1;
                    stop_granted <= 1'b1;
                end else begin
                    wait_instead <= 1'b1;
                end
            end
        end
    end

endmodule // watchdog_reset_timer

`default_nettype wire

// [test/wdg_checker.sv]
// port assertions for the watchdog reset timer
// bound into the design; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module wdg_checker (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       activation_select_option,
    input wire logic       external_stop_control_option,
    input wire logic       nonmaskable_interrupt_pin,
    input wire logic       reg_write,
    input wire logic       stop_request,
    input wire logic       stop_exit,
    input wire logic       watchdog_active,
    input wire logic       stop_granted,
    input wire logic       wait_instead,
    input wire logic       reset_pin_n,
    input wire logic       reset_pin_oe,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] watchdog_count_register
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // stop judged by an active watchdog; go means it may freeze
    wire take = stop_request && !stop_granted && !stop_exit && watchdog_active;
    wire go = take && external_stop_control_option && nonmaskable_interrupt_pin;
    a_oe_pin: assert property (reset_pin_oe == !reset_pin_n) else $error("oe");
    a_pulse_len: assert property ($fell(reset_pin_n) |-> (!reset_pin_n)[*8]
        ##1 !reset_pin_n ##1 !reset_pin_n ##1 reset_pin_n) else $error("pulse");
    a_pulse_why: assert property ($fell(reset_pin_n) |->
        !$past(watchdog_count_register[1], 2)) else $error("cause");
    a_act_kept: assert property (watchdog_active |=> watchdog_active) else $error("act");
    a_hw_bit: assert property (activation_select_option && watchdog_active |->
        watchdog_count_register[0]) else $error("bit0");
    a_wr_load: assert property (reg_write |=>
        watchdog_count_register[7:1] == $past(reg_wdata[7:1])) else $error("load");
    a_stop_go: assert property (go |=> stop_granted) else $error("stop");
    a_stop_wait: assert property (take && !go |=> wait_instead && !stop_granted)
        else $error("wait");
    a_count_frozen: assert property (stop_granted && watchdog_active && !reg_write |=>
        $stable(watchdog_count_register)) else $error("frozen");
    c_pulse: cover property ($fell(reset_pin_n));
    c_frozen: cover property (stop_granted && watchdog_active);
    c_wait: cover property (wait_instead);
endmodule // wdg_checker
bind watchdog_reset_timer wdg_checker u_chk (.*);
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the watchdog reset timer
// inputs change at the rising edge; the checker binds itself
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic       core_clk = 0, reset_n = 0, hw = 0, ext = 0, pin = 0, wr_en = 0;
    logic       stop_req = 0, stop_ex = 0, act, gnt, wti, rpn, roe;
    logic [7:0] wd = 8'h00, rd;
    int         n_fail = 0, n_tests = 0, cyc = 0;
    // stop rows: hw option, ext control, pin, granted, wait
    logic [4:0] rows [5] = '{5'b11110, 5'b11001, 5'b10101, 5'b10001, 5'b00010};
    watchdog_reset_timer dut (.core_clk(core_clk), .reset_n(reset_n),
        .activation_select_option(hw), .external_stop_control_option(ext),
        .nonmaskable_interrupt_pin(pin), .reg_write(wr_en), .reg_wdata(wd),
        .stop_request(stop_req), .stop_exit(stop_ex), .watchdog_count_register(rd),
        .watchdog_active(act), .stop_granted(gnt), .wait_instead(wti),
        .reset_pin_n(rpn), .reset_pin_oe(roe));
    initial forever #25 core_clk = ~core_clk;
    // cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 15000) n_fail++;
        if (cyc == 15000) final_report();
    end
    task final_report;
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) n_fail++;
        if (g !== e) $display("MISMATCH %s exp %h got %h", nm, e, g);
    endtask
    task tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task rst(input logic h);
        @(posedge core_clk) reset_n <= 0;
        hw <= h;
        tk(10);
        chk("reset", 8'hFE, rd);
        @(posedge core_clk) reset_n <= 1;
        tk(3);
    endtask
    task wr(input logic [7:0] d);
        @(posedge core_clk) wr_en <= 1;
        wd <= d;
        @(posedge core_clk) wr_en <= 0;
        tk(2);
    endtask
    task wlow(input int n);
        for (int k = 0; k < n && rpn !== 1'b0; k++) tk(1);
    endtask
    initial begin
        for (int i = 0; i < 5; i++) begin
            rst(rows[i][4]);
            @(posedge core_clk) {ext, pin} <= rows[i][3:2];
            @(posedge core_clk) stop_req <= 1;
            @(posedge core_clk) stop_req <= 0;
            #1 chk("stop", {6'h00, rows[i][1:0]}, {6'h00, gnt, wti});
            tk(i == 0 ? 3100 : 1);
            if (i == 0) chk("frozen", 8'hFF, rd);
            @(posedge core_clk) stop_ex <= 1;
            @(posedge core_clk) stop_ex <= 0;
            tk(1);
            chk("exit", 8'h00, {7'h00, gnt});
        end
        // hw option bit stays set; sw option idles, then sticks once set
        rst(1);
        wr(8'h02);
        chk("hwbit", 8'h03, rd);
        rst(0);
        chk("idle", 8'h00, {7'h00, act});
        wr(8'hFB);
        chk("act", 8'h01, {7'h00, act});
        wr(8'hFE);
        chk("sticky", 8'hFF, rd);
        wr(8'hFD);
        wlow(4);
        chk("swreset", 8'h00, {7'h00, rpn});
        chk("drive", 8'h01, {7'h00, roe});
        // reload 83h: one step of 3072 cycles, then a second ends in reset
        rst(0);
        wr(8'h83);
        tk(3040);
        chk("early", 8'h83, rd);
        tk(40);
        chk("step", 8'h03, rd);
        tk(3040);
        chk("hold", 8'h01, {7'h00, rpn});
        wlow(40);
        chk("fire", 8'h00, {7'h00, rpn});
        chk("expired", 8'hFD, rd);
        final_report();
    end
endmodule // tb
`default_nettype wire
